/* src/odc_params.svh */
// Constants for the driver calibration and termination block
`ifndef ODC_PARAMS_SVH
`define ODC_PARAMS_SVH
// Register offsets (byte addresses)
`define ODC_REG_CTRL 8'h00
`define ODC_REG_STAT 8'h04
`define ODC_REG_EMR1 8'h08
// Control register bits
`define ODC_CTRL_TERM_BLOCK 0
`define ODC_CTRL_CAL_LOCK 1
// Extended register one address bit positions
`define ODC_A_REDUCED 1
`define ODC_A_RTT0 2
`define ODC_A_AL_LO 3
`define ODC_A_AL_HI 5
`define ODC_A_RTT1 6
`define ODC_A_OCD_LO 7
`define ODC_A_OCD_HI 9
`define ODC_A_DQSN_DIS 10
// Mode register bit positions for cas latency
`define ODC_A_CL_LO 4
`define ODC_A_CL_HI 6
// Reset values
`define ODC_CL_RST 3'h3
`define ODC_AL_RST 3'h0
`define ODC_EMR1_RST 13'h0000
// Nominal impedance after restore default, ohms
`define ODC_IMP_OHM 18
// Timing: clock period and delays in ns
`define ODC_CLK_NS 10
`define ODC_OIT_NS 12
`define ODC_MOD_MIN_NS 0
`define ODC_MOD_MAX_NS 12
// Least times round up, at least one cycle
`define ODC_OIT_CYC (((`ODC_OIT_NS + `ODC_CLK_NS - 1) / `ODC_CLK_NS) > 0 ? \
    ((`ODC_OIT_NS + `ODC_CLK_NS - 1) / `ODC_CLK_NS) : 1)
`define ODC_MOD_MIN_CYC (((`ODC_MOD_MIN_NS + `ODC_CLK_NS - 1) / `ODC_CLK_NS) > 0 ? \
    ((`ODC_MOD_MIN_NS + `ODC_CLK_NS - 1) / `ODC_CLK_NS) : 1)
// Longest time rounds down, at least one cycle
`define ODC_MOD_MAX_CYC ((`ODC_MOD_MAX_NS / `ODC_CLK_NS) > 0 ? (`ODC_MOD_MAX_NS / `ODC_CLK_NS) : 1)
`endif

/* src/odc_pkg.sv */
// Types shared by the calibration and termination block
`default_nettype none
package odc_pkg;
    // Calibration sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_DRIVE = 4'b0010,
        ST_ADJ_WAIT = 4'b0100,
        ST_ADJ_CAPT = 4'b1000
    } odc_state_t;
    // Calibration operation field codes
    typedef enum logic [2:0] {
        OP_EXIT = 3'h0,
        OP_DRIVE_HI = 3'h1,
        OP_DRIVE_LO = 3'h2,
        OP_ADJUST = 3'h4,
        OP_DEFAULT = 3'h7
    } odc_op_t;
    // Driver strength step
    typedef logic [3:0] odc_step_t;
endpackage
`default_nettype wire

/* src/odc_step_if.sv */
// Step request and step value between sequencer and counter
`default_nettype none
interface odc_step_if;
    import odc_pkg::*;
    logic inc;
    logic dec;
    logic load;
    odc_step_t load_val;
    odc_step_t step;
    modport ctl (output inc, output dec, output load, output load_val, input step);
    modport ctr (input inc, input dec, input load, input load_val, output step);
endinterface
`default_nettype wire

/* src/odc_step_ctr.sv */
// Saturating sixteen-step driver strength counter
`default_nettype none
module odc_step_ctr
    import odc_pkg::*;
#(
    parameter odc_step_t RST_STEP = 4'h8
)(
    input wire logic clk_i,
    input wire logic resetn_i,
    odc_step_if.ctr st
);
    import odc_pkg::*;

    // Step value, start point is a parameter, not assumed
    odc_step_t step_ff;
    odc_step_t nxt_step;

    // Load wins; inc or dec stop at the ends
    always_comb
    begin
        nxt_step = step_ff;
        if (st.load)
        begin
            nxt_step = st.load_val;
        end
        else if (st.inc && !st.dec && step_ff != 4'hf)
        begin
            nxt_step = step_ff + 4'h1;
        end
        else if (st.dec && !st.inc && step_ff != 4'h0)
        begin
            nxt_step = step_ff - 4'h1;
        end
    end

    // Step register
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            step_ff <= RST_STEP;
        end
        else
        begin
            step_ff <= nxt_step;
        end
    end

    assign st.step = step_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    step_top_sat_a: assert property (step_ff == 4'hf && st.inc && !st.load |=> step_ff == 4'hf)
        else $error("step passed the top limit");
    step_bot_sat_a: assert property (step_ff == 4'h0 && st.dec && !st.load |=> step_ff == 4'h0)
        else $error("step passed the bottom limit");
endmodule // odc_step_ctr
`default_nettype wire

/* src/odc_top.sv */
// Driver impedance calibration and on-die termination control
//
// Operation
// - Decode calibration field: exit, drive, adjust, default
// - Drive-high: data, strobe high; complement low
// - Drive-low: data, strobe low; complement high
// - Restore default gives nominal 18 ohm drivers
// - Calibration only at full strength drive
// - Decode adjust code into pull-up/pull-down steps
// - One strength setting for all lines
// - Step counter spans sixteen steps, saturates
// - Default step position is not assumed
// - Code bits in fixed order, any burst
// - Drivers on/off fixed delay after command
// - Termination per data, strobe, mask under pin
// - Complement strobe terminated only if enabled
// - Termination forced off in self refresh
// - Pin switches; register field picks resistor
// - New termination applied within update window
// - Termination selection from address bits 2, 6
//
// Added by the designer: the plain strobed port and the register addresses.
`include "odc_params.svh"
`default_nettype none
module odc_top
    import odc_pkg::*;
#(
    parameter int DQ_W = 16,
    parameter odc_step_t RST_STEP = 4'h8
)(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic cke_i,
    input wire logic cs_n_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire logic [2:0] ba_i,
    input wire logic [12:0] addr_i,
    input wire logic [DQ_W-1:0] dq_i,
    input wire logic on_die_termination_i,
    input wire logic self_refresh_i,
    output logic [DQ_W-1:0] dq_o,
    output logic dq_oe_o,
    output logic [1:0] dqs_o,
    output logic [1:0] dqs_n_o,
    output logic dqs_oe_o,
    output odc_pkg::odc_step_t pullup_step_o,
    output odc_pkg::odc_step_t pulldown_step_o,
    output logic cal_default_o,
    output logic [1:0] rtt_sel_o,
    output logic term_dq_en_o,
    output logic term_dqs_n_en_o,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o
);
    import odc_pkg::*;

    localparam int OIT_A = `ODC_OIT_CYC;
    localparam int MOD_A = `ODC_MOD_MIN_CYC;
    localparam logic [3:0] OIT_CYC = 4'(`ODC_OIT_CYC);
    localparam logic [3:0] MOD_CYC = 4'(`ODC_MOD_MIN_CYC);
    localparam int SW = 23 + DQ_W;

    // Two-stage synchroniser for every pin input
    logic [SW-1:0] sync1_ff;
    logic [SW-1:0] sync2_ff;
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end
        else
        begin
            sync1_ff <= {cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, ba_i, addr_i,
                         on_die_termination_i, self_refresh_i, dq_i};
            sync2_ff <= sync1_ff;
        end
    end

    // Synchronised pin views
    logic cke_s;
    logic [3:0] cmd_s;
    logic [2:0] ba_s;
    logic [12:0] a_s;
    logic odt_s;
    logic sref_s;
    logic [DQ_W-1:0] dq_s;
    assign {cke_s, cmd_s, ba_s, a_s, odt_s, sref_s, dq_s} = sync2_ff;

    // Mode register writes: all command lines low with clock enable
    logic mrs_any;
    logic mrs0;
    logic emr1_wr;
    odc_op_t op;
    assign mrs_any = cke_s && cmd_s == 4'h0;
    assign mrs0 = mrs_any && ba_s == 3'h0;
    assign emr1_wr = mrs_any && ba_s == 3'h1;
    assign op = odc_op_t'(a_s[`ODC_A_OCD_HI:`ODC_A_OCD_LO]);

    // Control register: blocks termination, locks out calibration
    logic [1:0] ctrl_ff;
    logic cal_lock;
    assign cal_lock = ctrl_ff[`ODC_CTRL_CAL_LOCK];

    // Calibration command strobes
    logic cal_cmd;
    logic drv_cmd;
    logic exit_cmd;
    logic adj_cmd;
    logic def_cmd;
    assign cal_cmd = emr1_wr && !cal_lock;
    assign drv_cmd = cal_cmd && (op == OP_DRIVE_HI || op == OP_DRIVE_LO);
    assign exit_cmd = cal_cmd && op == OP_EXIT;
    assign adj_cmd = cal_cmd && op == OP_ADJUST;
    assign def_cmd = cal_cmd && op == OP_DEFAULT;

    // Register fields that take effect at once
    logic [12:0] emr1_ff;
    logic [2:0] cl_ff;
    logic reduced;
    logic [2:0] al;
    logic dqsn_dis;
    assign reduced = emr1_ff[`ODC_A_REDUCED];
    assign al = emr1_ff[`ODC_A_AL_HI:`ODC_A_AL_LO];
    assign dqsn_dis = emr1_ff[`ODC_A_DQSN_DIS];
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            emr1_ff <= `ODC_EMR1_RST;
            cl_ff <= `ODC_CL_RST;
        end
        else
        begin
            if (emr1_wr)
            begin
                emr1_ff <= a_s;
            end
            if (mrs0)
            begin
                cl_ff <= a_s[`ODC_A_CL_HI:`ODC_A_CL_LO];
            end
        end
    end

    // Sequencer state and adjust capture
    odc_state_t state_ff;
    logic [4:0] wait_ff;
    logic [1:0] beat_ff;
    logic [3:0] code_ff;
    logic adj_done_ff;
    logic [4:0] wl;
    // Code comes at additive plus cas minus one; additive is the value held
    assign wl = 5'(al) + 5'(cl_ff) - 5'h1;

    // Walks drive and adjust phases; a new calibration command restarts it
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_ff <= ST_IDLE;
            wait_ff <= 5'h0;
            beat_ff <= 2'h0;
            code_ff <= 4'h0;
            adj_done_ff <= 1'b0;
        end
        else
        begin
            adj_done_ff <= 1'b0;
            if (drv_cmd)
            begin
                state_ff <= ST_DRIVE;
            end
            else if (exit_cmd || def_cmd)
            begin
                state_ff <= ST_IDLE;
            end
            else if (adj_cmd)
            begin
                state_ff <= ST_ADJ_WAIT;
                wait_ff <= 5'h1;
            end
            else
            begin
                unique case (state_ff)
                    ST_IDLE, ST_DRIVE:
                    begin
                        state_ff <= state_ff;
                    end
                    ST_ADJ_WAIT:
                    begin
                        // First bit time lands at the write latency
                        if (wait_ff >= wl)
                        begin
                            code_ff <= {code_ff[2:0], dq_s[0]};
                            beat_ff <= 2'h1;
                            state_ff <= ST_ADJ_CAPT;
                        end
                        else
                        begin
                            wait_ff <= wait_ff + 5'h1;
                        end
                    end
                    ST_ADJ_CAPT:
                    begin
                        // Fixed order: bit time zero ends up in code bit 3
                        code_ff <= {code_ff[2:0], dq_s[0]};
                        beat_ff <= beat_ff + 2'h1;
                        if (beat_ff == 2'h3)
                        begin
                            adj_done_ff <= 1'b1;
                            state_ff <= ST_IDLE;
                        end
                    end
                    default:
                    begin
                        state_ff <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Adjust code decode; reserved codes step nothing
    logic up_inc;
    logic up_dec;
    logic dn_inc;
    logic dn_dec;
    always_comb
    begin
        {up_inc, up_dec, dn_inc, dn_dec} = 4'h0;
        unique case (code_ff)
            4'h1: {up_inc, up_dec, dn_inc, dn_dec} = 4'h8;
            4'h2: {up_inc, up_dec, dn_inc, dn_dec} = 4'h4;
            4'h4: {up_inc, up_dec, dn_inc, dn_dec} = 4'h2;
            4'h8: {up_inc, up_dec, dn_inc, dn_dec} = 4'h1;
            4'h5: {up_inc, up_dec, dn_inc, dn_dec} = 4'ha;
            4'h6: {up_inc, up_dec, dn_inc, dn_dec} = 4'h6;
            4'h9: {up_inc, up_dec, dn_inc, dn_dec} = 4'h9;
            4'ha: {up_inc, up_dec, dn_inc, dn_dec} = 4'h5;
            default: {up_inc, up_dec, dn_inc, dn_dec} = 4'h0;
        endcase
    end

    // One pull-up and one pull-down setting shared by all lines
    odc_step_if up_if ();
    odc_step_if dn_if ();
    logic step_go;
    assign step_go = adj_done_ff && !reduced;
    assign up_if.inc = step_go && up_inc;
    assign up_if.dec = step_go && up_dec;
    assign up_if.load = def_cmd;
    assign up_if.load_val = RST_STEP;
    assign dn_if.inc = step_go && dn_inc;
    assign dn_if.dec = step_go && dn_dec;
    assign dn_if.load = def_cmd;
    assign dn_if.load_val = RST_STEP;
    odc_step_ctr #(.RST_STEP(RST_STEP)) u_up (.clk_i(clk_i), .resetn_i(resetn_i), .st(up_if.ctr));
    odc_step_ctr #(.RST_STEP(RST_STEP)) u_dn (.clk_i(clk_i), .resetn_i(resetn_i), .st(dn_if.ctr));
    assign pullup_step_o = up_if.step;
    assign pulldown_step_o = dn_if.step;

    // Default characteristics hold until adjust is used or strength drops
    logic def_ff;
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            def_ff <= 1'b0;
            cal_default_o <= 1'b0;
        end
        else
        begin
            if (def_cmd)
            begin
                def_ff <= 1'b1;
            end
            else if (adj_cmd)
            begin
                def_ff <= 1'b0;
            end
            cal_default_o <= (def_ff || def_cmd) && !adj_cmd && !reduced;
        end
    end

    // Drive mode pins change one fixed delay after entry or exit
    logic [1:0] drv_pend_ff;
    logic [3:0] oit_ff;
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            drv_pend_ff <= 2'h0;
            oit_ff <= 4'h0;
            dq_o <= '0;
            dq_oe_o <= 1'b0;
            dqs_o <= 2'h0;
            dqs_n_o <= 2'h0;
            dqs_oe_o <= 1'b0;
        end
        else
        begin
            if (drv_cmd || (exit_cmd && state_ff == ST_DRIVE))
            begin
                drv_pend_ff <= drv_cmd ? {op == OP_DRIVE_LO, op == OP_DRIVE_HI} : 2'h0;
                oit_ff <= OIT_CYC;
            end
            else if (oit_ff != 4'h0)
            begin
                oit_ff <= oit_ff - 4'h1;
                if (oit_ff == 4'h1)
                begin
                    dq_oe_o <= drv_pend_ff != 2'h0;
                    dqs_oe_o <= drv_pend_ff != 2'h0;
                    dq_o <= {DQ_W{drv_pend_ff[0]}};
                    dqs_o <= {2{drv_pend_ff[0]}};
                    dqs_n_o <= {2{drv_pend_ff[1]}};
                end
            end
        end
    end

    // Termination selection waits out the update window
    logic [1:0] rtt_new_ff;
    logic rtt_pend_ff;
    logic [3:0] mod_ff;
    logic [1:0] rtt_wr;
    assign rtt_wr = {a_s[`ODC_A_RTT1], a_s[`ODC_A_RTT0]};
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rtt_new_ff <= 2'h0;
            rtt_pend_ff <= 1'b0;
            mod_ff <= 4'h0;
            rtt_sel_o <= 2'h0;
        end
        else if (emr1_wr && rtt_wr != rtt_sel_o)
        begin
            rtt_new_ff <= rtt_wr;
            rtt_pend_ff <= 1'b1;
            mod_ff <= MOD_CYC;
        end
        else if (rtt_pend_ff)
        begin
            mod_ff <= mod_ff - 4'h1;
            if (mod_ff <= 4'h1)
            begin
                rtt_sel_o <= rtt_new_ff;
                rtt_pend_ff <= 1'b0;
            end
        end
    end

    // Pin closes the switch; off in self refresh or when blocked
    logic term_on;
    assign term_on = odt_s && !sref_s && rtt_sel_o != 2'h0 && !ctrl_ff[`ODC_CTRL_TERM_BLOCK];
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            term_dq_en_o <= 1'b0;
            term_dqs_n_en_o <= 1'b0;
        end
        else
        begin
            term_dq_en_o <= term_on;
            term_dqs_n_en_o <= term_on && !dqsn_dis;
        end
    end

    // Register bus writes
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ctrl_ff <= 2'h0;
        end
        else if (reg_wr_i && reg_addr_i == `ODC_REG_CTRL)
        begin
            ctrl_ff <= reg_wdata_i[1:0];
        end
    end

    // Register bus reads, answer one cycle later; unmapped reads zero
    logic [31:0] nxt_rdata;
    always_comb
    begin
        nxt_rdata = 32'h0;
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                `ODC_REG_CTRL: nxt_rdata = {30'h0, ctrl_ff};
                `ODC_REG_STAT: nxt_rdata = {8'h0, 8'(`ODC_IMP_OHM), state_ff, dq_oe_o, cal_default_o,
                                            rtt_sel_o, pulldown_step_o, pullup_step_o};
                `ODC_REG_EMR1: nxt_rdata = {19'h0, emr1_ff};
                default: nxt_rdata = 32'h0;
            endcase
        end
    end
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            reg_rdata_o <= 32'h0;
        end
        else
        begin
            reg_rdata_o <= nxt_rdata;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence drv_enter_s;
        drv_cmd ##1 !emr1_wr;
    endsequence

    drive_high_pins_a: assert property (dq_oe_o && dqs_o[0] |-> &dq_o && dqs_n_o == 2'h0)
        else $error("drive-high pin levels wrong");
    drive_low_pins_a: assert property (dq_oe_o && !dqs_o[0] |-> dq_o == '0 && dqs_n_o == 2'h3)
        else $error("drive-low pin levels wrong");
    drive_on_delay_a: assert property (drv_enter_s |-> ##OIT_A dq_oe_o)
        else $error("drivers not on after fixed delay");
    up_step_inc_a: assert property (step_go && code_ff == 4'h1 && pullup_step_o != 4'hf && !def_cmd
        |=> pullup_step_o == $past(pullup_step_o) + 4'h1)
        else $error("pull-up did not step up");
    reserved_code_a: assert property (adj_done_ff && code_ff == 4'h3 && !def_cmd
        |=> $stable(pullup_step_o) && $stable(pulldown_step_o))
        else $error("reserved code changed strength");
    default_reduced_a: assert property (cal_default_o |-> !$past(reduced))
        else $error("default valid at reduced strength");
    sref_term_off_a: assert property (sref_s |=> !term_dq_en_o && !term_dqs_n_en_o)
        else $error("termination on in self refresh");
    dqsn_term_a: assert property (term_dqs_n_en_o |-> term_dq_en_o && !$past(dqsn_dis))
        else $error("complement strobe terminated while disabled");
    rtt_update_a: assert property ($rose(rtt_pend_ff) |-> ##[1:MOD_A] (rtt_sel_o == rtt_new_ff))
        else $error("termination value not applied in window");
endmodule // odc_top
`default_nettype wire

/* sim/odc_ctl_model.sv */
// Memory controller model that drives the command, address, data and termination pins
`default_nettype none
module odc_ctl_model #(
    parameter int AL = 0,
    parameter int CL = 3
)(
    input wire logic clk_i,
    output logic cke_o,
    output logic cs_n_o,
    output logic ras_n_o,
    output logic cas_n_o,
    output logic we_n_o,
    output logic [2:0] ba_o,
    output logic [12:0] addr_o,
    output logic [15:0] dq_o,
    output logic odt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle pins; clock enable drops only for a refused command, never inside an update window
    initial
    begin
        cke_o = 1'b1;
        {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hf;
        ba_o = 3'h0;
        addr_o = 13'h0;
        dq_o = 16'h0;
        odt_o = 1'b0;
    end
    // One command cycle with a chosen clock enable and command code; address inverted after it
    task automatic raw(input logic c, input logic [3:0] k, input logic [2:0] ba, input logic [12:0] a);
        @(posedge clk_i);
        cke_o <= c;
        {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= k;
        ba_o <= ba;
        addr_o <= a;
        @(posedge clk_i);
        cke_o <= 1'b1;
        {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= 4'hf;
        addr_o <= ~a;
    endtask
    // Mode register write command
    task automatic cmd(input logic [2:0] ba, input logic [12:0] a);
        raw(1'b1, 4'h0, ba, a);
    endtask
    // Mode register: burst length four and the cas latency
    task automatic mrs();
        cmd(3'h0, {6'h0, CL[2:0], 1'b0, 3'h2});
    endtask
    // Termination pin change, launched after an edge
    task automatic set_odt(input logic v);
        @(posedge clk_i);
        odt_o <= v;
    endtask
    // Extended register one write with termination parked low around it
    task automatic emr1(input logic [12:0] a);
        odt_o <= 1'b0;
        repeat (3) @(posedge clk_i);
        cmd(3'h1, a);
        repeat (3) @(posedge clk_i);
    endtask
    // Adjust command, the code on all data lines from bit time zero, then exit
    task automatic adjust(input logic [12:0] base, input logic [3:0] code);
        logic [12:0] a;
        a = base;
        a[9:7] = 3'h4;
        a[5:3] = AL[2:0];
        cmd(3'h1, a);
        repeat (AL + CL - 2) @(posedge clk_i);
        for (int i = 3; i >= 0; i--)
        begin
            dq_o <= {16{code[i]}};
            @(posedge clk_i);
        end
        dq_o <= ~dq_o;
        emr1(base & 13'h1c7f);
    endtask
endmodule // odc_ctl_model
`default_nettype wire

/* sim/odc_top_bench.sv */
// Self-checking bench for the driver calibration and termination block
`default_nettype none
module odc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import odc_pkg::*;
    localparam odc_step_t RS = 4'h5; // Off-centre start, nothing may assume a fixed one
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic cke, cs_n, ras_n, cas_n, we_n, on_die_termination, sr, dq_oe, dqs_oe, cdef, tdq, tdqsn, rwr, rrd;
    logic [2:0] ba;
    logic [12:0] addr;
    logic [15:0] dq, dq_o;
    logic [1:0] dqs, dqs_n, rtt;
    odc_step_t pu, pd;
    logic [7:0] ra;
    logic [31:0] rwd, rdata;
    int n_fail = 0;
    int checks_done = 0;
    int eu = RS;
    int ed = RS;
    logic [3:0] codes [10] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'h6, 4'h9, 4'ha, 4'h0, 4'h3};
    // Free-running 100 MHz clock
    always #5 clk = ~clk;
    odc_ctl_model u_ctl (.clk_i(clk), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n),
        .we_n_o(we_n), .ba_o(ba), .addr_o(addr), .dq_o(dq), .odt_o(on_die_termination));
    odc_top #(.RST_STEP(RS)) u_dut (.clk_i(clk), .resetn_i(resetn), .cke_i(cke), .cs_n_i(cs_n),
        .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .ba_i(ba), .addr_i(addr), .dq_i(dq),
        .on_die_termination_i(on_die_termination), .self_refresh_i(sr), .dq_o(dq_o), .dq_oe_o(dq_oe), .dqs_o(dqs),
        .dqs_n_o(dqs_n), .dqs_oe_o(dqs_oe), .pullup_step_o(pu), .pulldown_step_o(pd),
        .cal_default_o(cdef), .rtt_sel_o(rtt), .term_dq_en_o(tdq), .term_dqs_n_en_o(tdqsn),
        .reg_addr_i(ra), .reg_wdata_i(rwd), .reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(rdata));
    // Count and report one comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Single exit point of the run
    task automatic end_sim();
        $display("checks=%0d errors=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic pause(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        ra <= a;
        rwd <= d;
        rwr <= 1'b1;
        @(posedge clk);
        rwr <= 1'b0;
    endtask
    // Read data is only valid in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        ra <= a;
        rrd <= 1'b1;
        @(posedge clk);
        rrd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // Bounded wait for the drive enable to reach a level
    task automatic wait_oe(input logic v);
        int n;
        n = 0;
        while (dq_oe !== v && n < 40)
        begin
            pause(1);
            n++;
        end
        if (dq_oe !== v)
        begin
            n_fail++;
            end_sim();
        end
    endtask
    // Adjust step; the expected counts saturate at both ends, reserved codes move nothing
    task automatic adj(input logic [12:0] base, input logic [3:0] code, input bit take);
        u_ctl.adjust(base, code);
        pause(4);
        if (take && code inside {4'h1, 4'h5, 4'h9}) eu = (eu < 15) ? eu + 1 : 15;
        if (take && code inside {4'h2, 4'h6, 4'ha}) eu = (eu > 0) ? eu - 1 : 0;
        if (take && code inside {4'h4, 4'h5, 4'h6}) ed = (ed < 15) ? ed + 1 : 15;
        if (take && code inside {4'h8, 4'h9, 4'ha}) ed = (ed > 0) ? ed - 1 : 0;
        chk(32'(pu), eu[31:0]);
        chk(32'(pd), ed[31:0]);
    endtask
    // Main sequence
    initial
    begin
        rwr = 1'b0;
        rrd = 1'b0;
        ra = 8'h00;
        rwd = 32'h0;
        sr = 1'b0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        pause(2);
        rd(8'h04, {8'h00, 8'h12, 4'h1, 4'h0, RS, RS});
        u_ctl.mrs();
        u_ctl.emr1(13'h0);
        for (int m = 1; m <= 2; m++)
        begin
            u_ctl.emr1(13'(m << 7));
            wait_oe(1'b1);
            chk(32'(dq_o), (m == 1) ? 32'hffff : 32'h0);
            chk(32'({dqs, dqs_n, dqs_oe}), (m == 1) ? 32'h19 : 32'h7);
            u_ctl.emr1(13'h0);
            wait_oe(1'b0);
            chk(32'(dqs_oe), 32'h0);
        end
        // Refused commands: clock enable low, not a mode write, another bank
        u_ctl.raw(1'b0, 4'h0, 3'h1, 13'h080);
        u_ctl.raw(1'b1, 4'h1, 3'h1, 13'h080);
        u_ctl.raw(1'b1, 4'h0, 3'h2, 13'h080);
        pause(8);
        rd(8'h04, {8'h00, 8'h12, 4'h1, 4'h0, RS, RS});
        rd(8'h08, 32'h0);
        foreach (codes[i]) adj(13'h0, codes[i], 1'b1);
        repeat (11) adj(13'h0, 4'h5, 1'b1);
        repeat (16) adj(13'h0, 4'ha, 1'b1);
        adj(13'h002, 4'h5, 1'b0);
        wr(8'h00, 32'h2);
        rd(8'h00, 32'h2);
        adj(13'h0, 4'h5, 1'b0);
        wr(8'h00, 32'h0);
        u_ctl.emr1(13'h380);
        u_ctl.emr1(13'h0);
        pause(4);
        eu = RS;
        ed = RS;
        chk(32'({cdef, pu, pd}), {23'h0, 1'b1, RS, RS});
        adj(13'h0, 4'h1, 1'b1);
        chk(32'(cdef), 32'h0);
        rd(8'h0c, 32'h0);
        wr(8'h10, 32'h3);
        rd(8'h00, 32'h0);
        for (int s = 1; s <= 3; s++)
        begin
            u_ctl.emr1(13'({s[1], 3'h0, s[0], 2'h0}));
            pause(1);
            chk(32'(rtt), s[31:0]);
            u_ctl.set_odt(1'b1);
            pause(4);
            chk(32'({tdq, tdqsn}), 32'h3);
        end
        sr <= 1'b1;
        pause(4);
        chk(32'({tdq, tdqsn}), 32'h0);
        sr <= 1'b0;
        wr(8'h00, 32'h1);
        pause(4);
        chk(32'(tdq), 32'h0);
        wr(8'h00, 32'h0);
        u_ctl.emr1(13'h404);
        u_ctl.set_odt(1'b1);
        pause(4);
        chk(32'({tdq, tdqsn}), 32'h2);
        rd(8'h08, 32'h404);
        end_sim();
    end
endmodule // odc_top_bench
`default_nettype wire
